/* File: hw/rls_top.sv */
// Receive clock / multiplex pins and serial LOS status stream with register slave
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rls_defines.svh"
module rls_top
  import rls_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Line side
  input wire logic external_reference_clock,
  input wire rls_chin_s [16:0] ch_in,
  // Per channel system pins
  output rls_chout_s [16:0] ch_out,
  // Serial LOS stream
  output logic reference_clock_out,
  output logic serial_line_los_status,
  output logic channel_zero_marker,
  output logic serial_oe_b
);

  rls_state_s s;
  rls_state_s n;
  rls_chvec_t los_vec;
  rls_chvec_t act_edge;
  logic req;
  logic ref_rise;
  logic evt_ready;
  logic evt_valid;
  logic evt_pop;
  rls_chvec_t evt_data;
  rls_dec_s dec;
  logic [31:0] nco_sum;

  function automatic rls_dec_s decode(input logic [9:0] adr);
    rls_dec_s d;
    d.ch = adr[6:2];
    d.kind = RLS_R_NONE;
    if (adr == `RLS_CTRL_OFS)
      d.kind = RLS_R_CTRL;
    else if (adr == `RLS_LOS_OFS)
      d.kind = RLS_R_LOS;
    else if (adr == `RLS_EVT_OFS)
      d.kind = RLS_R_EVT;
    else if (adr[9:8] == `RLS_CFGA_PAGE && adr[7] == 1'b0 && adr[1:0] == 2'h0
             && adr[6:2] <= `RLS_LAST_CH)
      d.kind = RLS_R_CFGA;
    else if (adr[9:8] == `RLS_CFGB_PAGE && adr[7] == 1'b0 && adr[1:0] == 2'h0
             && adr[6:2] <= `RLS_LAST_CH)
      d.kind = RLS_R_CFGB;
    return d;
  endfunction

  function automatic logic mf_pick(input rls_mf_e sel, input rls_chin_s c);
    logic v;
    v = 1'b0;
    unique case (sel)
      RLS_MF_PATT: v = c.patt_match;
      RLS_MF_AIS: v = c.ais;
      RLS_MF_EXZ: v = c.exz;
      RLS_MF_BPV: v = c.bpv;
      RLS_MF_EXZ_BPV: v = c.exz | c.bpv;
      RLS_MF_LOS: v = c.los;
      RLS_MF_RCLK: v = c.rec_clk;
      RLS_MF_XOR: v = c.rail_pos ^ c.rail_neg;
    endcase
    return v;
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !s.wb_ack;
  assign dec = decode(wb_adr_i);
  assign evt_pop = req && !wb_we_i && dec.kind == RLS_R_EVT && evt_valid;
  assign wb_ack_o = s.wb_ack;
  assign wb_dat_o = s.wb_dat;
  assign ch_out = s.pins;
  assign reference_clock_out = s.ref_q;
  assign serial_line_los_status = s.los_bit;
  assign channel_zero_marker = s.marker;
  assign serial_oe_b = s.serial_oe_b;

  genvar gi;
  generate
    for (gi = 0; gi < `RLS_NCH; gi++)
    begin : g_ch
      assign los_vec[gi] = ch_in[gi].los;
      // Active edge of the recovered clock, polarity per channel
      assign act_edge[gi] = s.cfg_b[gi].edge_fall ? (s.rclk_d[gi] && !ch_in[gi].rec_clk)
                                                  : (!s.rclk_d[gi] && ch_in[gi].rec_clk);
    end
  endgenerate

  always_comb
  begin
    n = s;
    // First stage feeds only the second
    n.external_reference_clock_sync = {s.external_reference_clock_sync[0], external_reference_clock};

    // Register slave, one wait-free cycle to ack
    n.wb_ack = req;
    if (req)
    begin
      n.wb_dat = 32'h0;
      unique case (dec.kind)
        RLS_R_CTRL: n.wb_dat[`RLS_CTRL_FAST:`RLS_CTRL_EN] = {s.ctrl_fast, s.ctrl_en};
        RLS_R_LOS: n.wb_dat[16:0] = los_vec;
        RLS_R_EVT: n.wb_dat = {evt_valid, 14'h0, evt_data};
        RLS_R_CFGA: n.wb_dat[7:0] = s.cfg_a[dec.ch];
        RLS_R_CFGB: n.wb_dat[7:0] = s.cfg_b[dec.ch];
        RLS_R_NONE: n.wb_dat = 32'h0;
        default: n.wb_dat = 32'h0;
      endcase
      if (wb_we_i && wb_sel_i[0])
      begin
        unique case (dec.kind)
          RLS_R_CTRL:
          begin
            n.ctrl_en = wb_dat_i[`RLS_CTRL_EN];
            n.ctrl_fast = wb_dat_i[`RLS_CTRL_FAST];
          end
          RLS_R_CFGA: n.cfg_a[dec.ch] = rls_cfg_a_s'(wb_dat_i[7:0]);
          RLS_R_CFGB: n.cfg_b[dec.ch] = rls_cfg_b_s'(wb_dat_i[7:0]);
          default: n.ctrl_en = s.ctrl_en;
        endcase
      end
    end

    // Per channel data capture and pin multiplexing
    for (int i = 0; i < `RLS_NCH; i++)
    begin
      n.rclk_d[i] = ch_in[i].rec_clk;
      if (act_edge[i])
      begin
        n.pos_q[i] = ch_in[i].rail_pos ^ s.cfg_b[i].data_inv;
        n.neg_q[i] = ch_in[i].rail_neg ^ s.cfg_b[i].data_inv;
        n.mf_q[i] = mf_pick(s.cfg_b[i].mf_sel, ch_in[i]);
      end
      // A clock source is passed straight, retiming it would freeze it
      if (s.cfg_b[i].mf_sel == RLS_MF_RCLK)
        n.mf_q[i] = ch_in[i].rec_clk;
      if (ch_in[i].powerdown)
      begin
        n.pins[i].rec_clk_or_mf = 1'b0;
        n.pins[i].clk_oe_b = s.cfg_a[i].pd_hiz;
        n.pins[i].data_or_pos = 1'b0;
        n.pins[i].neg_or_mf = 1'b0;
        n.pins[i].data_oe_b = s.cfg_a[i].pd_hiz;
      end
      else
      begin
        n.pins[i].clk_oe_b = 1'b0;
        n.pins[i].data_oe_b = 1'b0;
        n.pins[i].data_or_pos = n.pos_q[i];
        if (s.cfg_a[i].mode == RLS_SINGLE_NRZ)
          n.pins[i].neg_or_mf = n.mf_q[i];
        else
          n.pins[i].neg_or_mf = n.neg_q[i];
        if (s.cfg_a[i].mode == RLS_DUAL_SLICED)
          n.pins[i].rec_clk_or_mf = n.mf_q[i];
        else if (ch_in[i].los)
          n.pins[i].rec_clk_or_mf = s.cfg_a[i].los_clk_high || s.external_reference_clock_sync[1];
        else
          n.pins[i].rec_clk_or_mf = ch_in[i].rec_clk;
      end
    end

    // Reference clock from a phase accumulator, the fast rate has no integer divisor
    n.nco = s.ctrl_en ? nco_sum : 32'h0;
    n.ref_q = n.nco[31];
    n.serial_oe_b = !s.ctrl_en;
    if (!s.ctrl_en)
      n.slot = 5'h0;
    else if (ref_rise)
    begin
      n.los_bit = los_vec[s.slot];
      n.marker = s.slot == 5'h0;
      n.slot = (s.slot == `RLS_LAST_CH) ? 5'h0 : s.slot + 5'h1;
    end

    // Change log: latest vector waits while the FIFO is full
    if (los_vec != s.los_prev)
    begin
      n.los_prev = los_vec;
      n.evt_vec = los_vec;
      n.evt_pending = 1'b1;
    end
    else if (s.evt_pending && evt_ready)
    begin
      n.evt_pending = 1'b0;
    end
  end

  // Sum kept outside the state process so the edge flag forms no loop
  assign nco_sum = s.nco + (s.ctrl_fast ? `RLS_NCO_STEP(`RLS_REF_FAST_HZ)
                                        : `RLS_NCO_STEP(`RLS_REF_SLOW_HZ));
  assign ref_rise = !s.ref_q && nco_sum[31] && s.ctrl_en;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.serial_oe_b <= 1'b1;
      s.cfg_a <= {`RLS_NCH{`RLS_CFGA_RST}};
      s.cfg_b <= {`RLS_NCH{`RLS_CFGB_RST}};
      s.ctrl_en <= `RLS_CTRL_RST;
      s.pins <= {`RLS_NCH{5'h0}};
    end
    else
    begin
      s <= n;
    end
  end

  rls_fifo #(
    .WIDTH(`RLS_FIFO_WIDTH),
    .DEPTH(`RLS_FIFO_DEPTH)
  ) u_evt_fifo (
    .clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(s.evt_pending && (los_vec == s.los_prev)),
    .in_ready(evt_ready),
    .in_data(s.evt_vec),
    .out_valid(evt_valid),
    .out_ready(evt_pop),
    .out_data(evt_data)
  );

  // Helper logic read only by the checks below
  logic los_pick;
  logic pos0_exp;
  logic [4:0] edge_cnt;
  logic seen_mark;
  assign los_pick = los_vec[s.slot];
  assign pos0_exp = ch_in[0].rail_pos ^ s.cfg_b[0].data_inv;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !s.ctrl_en)
    begin
      edge_cnt <= 5'h0;
      seen_mark <= 1'b0;
    end
    else if (ref_rise)
    begin
      edge_cnt <= n.marker ? 5'h1 : edge_cnt + 5'h1;
      seen_mark <= seen_mark || n.marker;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_slot0_edge;
    ref_rise && s.slot == 5'h0;
  endsequence

  sequence s_marker_pulse;
    s.marker && !s.serial_oe_b;
  endsequence

  property p_marker_slot0;
    s_slot0_edge |=> s_marker_pulse ##0 s.slot == 5'h1;
  endproperty
  a_marker_slot0: assert property (p_marker_slot0) else $error("marker not in slot 0");

  property p_marker_period;
    ref_rise && s.slot == 5'h0 && seen_mark |-> edge_cnt == 5'h11;
  endproperty
  a_marker_period: assert property (p_marker_period) else $error("marker period not 17");

  property p_serial_order;
    ref_rise |=> s.los_bit == $past(los_pick);
  endproperty
  a_serial_order: assert property (p_serial_order) else $error("serial LOS wrong slot");

  property p_serial_on_edge;
    $changed(s.los_bit) || $changed(s.marker) |-> $rose(s.ref_q);
  endproperty
  a_serial_on_edge: assert property (p_serial_on_edge) else $error("serial change off edge");

  property p_serial_hiz;
    !s.ctrl_en |=> s.serial_oe_b;
  endproperty
  a_serial_hiz: assert property (p_serial_hiz) else $error("serial pins not released");

  property p_data_edge;
    ((s.pos_q ^ $past(s.pos_q)) & ~$past(act_edge)) == 17'h0;
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved off active edge");

  property p_data_invert;
    act_edge[0] |=> s.pos_q[0] == $past(pos0_exp);
  endproperty
  a_data_invert: assert property (p_data_invert) else $error("data level wrong");

  property p_los_clk_high;
    ch_in[1].los && !ch_in[1].powerdown && s.cfg_a[1].los_clk_high
      && s.cfg_a[1].mode != RLS_DUAL_SLICED |=> s.pins[1].rec_clk_or_mf && !s.pins[1].clk_oe_b;
  endproperty
  a_los_clk_high: assert property (p_los_clk_high) else $error("clock not high in LOS");

  property p_powerdown;
    ch_in[2].powerdown |=> s.pins[2].clk_oe_b == $past(s.cfg_a[2].pd_hiz)
      && !s.pins[2].rec_clk_or_mf;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("powerdown pin state wrong");

  property p_sliced_mf;
    !ch_in[4].powerdown && s.cfg_a[4].mode == RLS_DUAL_SLICED
      |=> s.pins[4].rec_clk_or_mf == s.mf_q[4];
  endproperty
  a_sliced_mf: assert property (p_sliced_mf) else $error("sliced pin not multiplex");

  property p_clk_pass;
    !ch_in[0].powerdown && !ch_in[0].los && s.cfg_a[0].mode != RLS_DUAL_SLICED
      |=> s.pins[0].rec_clk_or_mf == $past(ch_in[0].rec_clk);
  endproperty
  a_clk_pass: assert property (p_clk_pass) else $error("recovered clock not passed");

  property p_mf_xor;
    act_edge[4] && s.cfg_b[4].mf_sel == RLS_MF_XOR
      |=> s.mf_q[4] == ($past(ch_in[4].rail_pos) ^ $past(ch_in[4].rail_neg));
  endproperty
  a_mf_xor: assert property (p_mf_xor) else $error("multiplex xor wrong");

endmodule

/* File: hw/rls_defines.svh */
// Offsets, field positions, reset values and clock rates of the rx clock / serial LOS block
`ifndef RLS_DEFINES_SVH
`define RLS_DEFINES_SVH

`define RLS_NCH 17
`define RLS_LAST_CH 5'h10

`define RLS_CTRL_OFS 10'h000
`define RLS_LOS_OFS 10'h004
`define RLS_EVT_OFS 10'h008
`define RLS_CFGA_PAGE 2'h1
`define RLS_CFGB_PAGE 2'h2

`define RLS_CTRL_EN 0
`define RLS_CTRL_FAST 1
`define RLS_EVT_VALID 31

`define RLS_CTRL_RST 1'h0
`define RLS_CFGA_RST 8'h00
`define RLS_CFGB_RST 8'h00

`define RLS_FIFO_DEPTH 32
`define RLS_FIFO_WIDTH 17

`define RLS_CLK_HZ 50000000
`define RLS_REF_SLOW_HZ 8000
`define RLS_REF_FAST_HZ 2048000
`define RLS_NCO_STEP(hz) (32'(((64'(hz)) << 32) / 64'(`RLS_CLK_HZ)))

`endif

/* File: hw/rls_pkg.sv */
// Types shared by the rx clock / serial LOS block
package rls_pkg;

  typedef logic [16:0] rls_chvec_t;

  typedef enum logic [1:0] {RLS_SINGLE_NRZ, RLS_DUAL_NRZ, RLS_DUAL_RZ, RLS_DUAL_SLICED} rls_rmode_e;

  typedef enum logic [2:0] {
    RLS_MF_PATT, RLS_MF_AIS, RLS_MF_EXZ, RLS_MF_BPV,
    RLS_MF_EXZ_BPV, RLS_MF_LOS, RLS_MF_RCLK, RLS_MF_XOR
  } rls_mf_e;

  typedef enum logic [2:0] {RLS_R_NONE, RLS_R_CTRL, RLS_R_LOS, RLS_R_EVT, RLS_R_CFGA, RLS_R_CFGB}
    rls_reg_e;

  typedef struct packed {
    logic los_clk_high;
    logic pd_hiz;
    logic [3:0] spare;
    rls_rmode_e mode;
  } rls_cfg_a_s;

  typedef struct packed {
    rls_mf_e mf_sel;
    logic edge_fall;
    logic data_inv;
    logic [2:0] spare;
  } rls_cfg_b_s;

  typedef struct packed {
    logic rec_clk;
    logic rail_pos;
    logic rail_neg;
    logic los;
    logic ais;
    logic exz;
    logic bpv;
    logic patt_match;
    logic powerdown;
  } rls_chin_s;

  typedef struct packed {
    logic rec_clk_or_mf;
    logic clk_oe_b;
    logic data_or_pos;
    logic neg_or_mf;
    logic data_oe_b;
  } rls_chout_s;

  typedef struct packed {
    rls_reg_e kind;
    logic [4:0] ch;
  } rls_dec_s;

  typedef struct packed {
    logic [1:0] external_reference_clock_sync;
    logic ctrl_en;
    logic ctrl_fast;
    rls_cfg_a_s [16:0] cfg_a;
    rls_cfg_b_s [16:0] cfg_b;
    rls_chvec_t rclk_d;
    rls_chvec_t pos_q;
    rls_chvec_t neg_q;
    rls_chvec_t mf_q;
    rls_chout_s [16:0] pins;
    logic [31:0] nco;
    logic ref_q;
    logic [4:0] slot;
    logic los_bit;
    logic marker;
    logic serial_oe_b;
    rls_chvec_t los_prev;
    logic evt_pending;
    rls_chvec_t evt_vec;
    logic wb_ack;
    logic [31:0] wb_dat;
  } rls_state_s;

endpackage

/* File: hw/rls_fifo.sv */
// Small FIFO with registered read data for the LOS change log
`timescale 1ns/1ps
module rls_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
    logic ovalid;
    logic [WIDTH-1:0] odata;
  } rls_fifo_st_s;

  rls_fifo_st_s s_reg;
  rls_fifo_st_s s_next;
  logic push;
  logic load;

  assign in_ready = s_reg.cnt != CW'(DEPTH);
  assign out_valid = s_reg.ovalid;
  assign out_data = s_reg.odata;
  assign push = in_valid && in_ready;
  assign load = (s_reg.cnt != '0) && (!s_reg.ovalid || out_ready);

  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = s_reg.wr + AW'(1);
    end
    if (load)
    begin
      s_next.odata = s_reg.mem[s_reg.rd];
      s_next.rd = s_reg.rd + AW'(1);
      s_next.ovalid = 1'b1;
    end
    else if (out_ready)
    begin
      s_next.ovalid = 1'b0;
    end
    s_next.cnt = s_reg.cnt + CW'(push) - CW'(load);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

endmodule

/* File: bench/rls_framer_model.sv */
// System-side framer model that collects the serial LOS frames
`timescale 1ns/1ps
module rls_framer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial status pins
  input wire logic ref_in,
  input wire logic los_in,
  input wire logic marker_in,
  input wire logic oe_b_in,
  // Collected results
  output logic [16:0] frame_vec,
  output logic frame_done,
  output logic [15:0] edges,
  output logic [15:0] markers,
  output logic [15:0] glitches,
  output logic [15:0] frame_err,
  output logic [15:0] period
);
  logic ref_d, los_d, mk_d, oe_d;
  logic [4:0] idx;
  logic [16:0] vec;
  logic [15:0] run;
  wire rise = ref_in & ~ref_d;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      {ref_d, los_d, mk_d, oe_d, idx, vec, run, frame_vec, frame_done} <= '0;
      {edges, markers, glitches, frame_err, period} <= '0;
    end
    else
    begin
      ref_d <= ref_in;
      los_d <= los_in;
      mk_d <= marker_in;
      oe_d <= oe_b_in;
      frame_done <= 1'b0;
      run <= rise ? 16'h1 : run + 16'h1;
      // Pins may only move with a reference rising edge
      // Pins float while released, so the first driven cycle is not compared
      if (!oe_b_in && !oe_d && !rise && (los_in != los_d || marker_in != mk_d))
        glitches <= glitches + 16'h1;
      // Released pins carry nothing; restart the frame hunt
      if (oe_b_in)
        idx <= 5'h0;
      else if (rise)
      begin
        edges <= edges + 16'h1;
        period <= run;
        if (marker_in)
        begin
          markers <= markers + 16'h1;
          vec[0] <= los_in;
          idx <= 5'h1;
          if (idx != 5'h0 && idx != 5'h11)
            frame_err <= frame_err + 16'h1;
        end
        else if (idx == 5'h11)
          frame_err <= frame_err + 16'h1;
        else if (idx != 5'h0)
        begin
          vec[idx] <= los_in;
          idx <= idx + 5'h1;
          if (idx == 5'h10)
          begin
            frame_done <= 1'b1;
            frame_vec <= {los_in, vec[15:0]};
          end
        end
      end
    end
  end
endmodule

/* File: bench/rls_top_tb.sv */
// Self-checking bench for the rx clock and serial LOS block
`timescale 1ns/1ps
module rls_top_tb
  import rls_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [9:0] wb_adr = 10'h000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic ext_clk = 1'b0;
  rls_chin_s [16:0] ch_in = '0;
  rls_chout_s [16:0] ch_out;
  logic ref_out, los_ser, marker, ser_oe_b, frame_done;
  logic [16:0] frame_vec;
  logic [15:0] edges, markers, glitches, frame_err, period;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [16:0] PAT = 17'h14a53;
  localparam logic [7:0] MF_EXP = 8'h99;

  always #10 ref_clk = ~ref_clk;

  rls_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .external_reference_clock(ext_clk),
    .ch_in(ch_in), .ch_out(ch_out), .reference_clock_out(ref_out),
    .serial_line_los_status(los_ser), .channel_zero_marker(marker), .serial_oe_b(ser_oe_b));

  // Released pins are seen as garbage by the far side, not as the last level
  rls_framer_model fm (.clk(ref_clk), .rst_b(rst_b), .ref_in(ref_out),
    .los_in(ser_oe_b ? ~los_ser : los_ser), .marker_in(ser_oe_b ? ~marker : marker),
    .oe_b_in(ser_oe_b), .frame_vec(frame_vec), .frame_done(frame_done),
    .edges(edges), .markers(markers), .glitches(glitches), .frame_err(frame_err),
    .period(period));

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Classic single cycle; request held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d,
    input logic [3:0] sel, output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, we, a, sel, d};
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (wb_ack !== 1'b1);
    q = wb_rdat;
    chk("wb ack latency", 2, k);
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask

  // Reads the change log until it reports empty
  task automatic drain(output int cnt, output logic [16:0] last);
    logic [31:0] q;
    cnt = 0;
    last = '0;
    do
    begin
      wb(1'b0, 10'h008, 32'h0, 4'hf, q);
      if (q[31] === 1'b1)
      begin
        cnt++;
        last = q[16:0];
      end
    end
    while (q[31] === 1'b1 && cnt < 40);
  endtask

  task automatic wait_frame();
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (frame_done !== 1'b1 && k < 1000);
    chk("frame wait", 1, frame_done);
  endtask

  task automatic wait_edge();
    logic [15:0] e0;
    int k;
    e0 = edges;
    k = 0;
    while (edges === e0 && k < 8000)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk("ref edge wait", 1, edges !== e0);
  endtask

  task automatic pulse(input int ch);
    ch_in[ch].rec_clk <= 1'b1;
    ticks(4);
    ch_in[ch].rec_clk <= 1'b0;
    ticks(4);
  endtask

  // Whole run stays well under this
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    int cnt;
    logic [16:0] lastv;
    logic [31:0] q;
    ticks(5);
    rst_b <= 1'b1;
    ticks(1);
    chk("ch_out reset", 1, ch_out === '0);
    chk("serial oe reset", 1, ser_oe_b);
    rdc("ctrl reset", 10'h000, 32'h0);
    rdc("cfg a reset", 10'h100, 32'h0);
    rdc("cfg b reset", 10'h240, 32'h0);
    wb(1'b1, 10'h000, 32'h3, 4'he, q);
    rdc("ctrl lane off", 10'h000, 32'h0);
    wr(10'h300, 32'hff);
    rdc("unmapped", 10'h300, 32'h0);
    wr(10'h204, 32'hf8);
    rdc("cfg b rw", 10'h204, 32'hf8);
    wr(10'h204, 32'h0);
    // Serial stream at the fast rate
    for (int k = 0; k < 17; k++)
      ch_in[k].los <= PAT[k];
    ticks(4);
    rdc("los live", 10'h004, {15'h0, PAT});
    wr(10'h004, 32'h0);
    rdc("los read only", 10'h004, {15'h0, PAT});
    drain(cnt, lastv);
    chk("event vector", {15'h0, PAT}, {15'h0, lastv});
    wr(10'h000, 32'h3);
    wait_frame();
    chk("frame 1", {15'h0, PAT}, {15'h0, frame_vec});
    wait_frame();
    chk("frame 2", {15'h0, PAT}, {15'h0, frame_vec});
    chk("markers", 32'h2, {16'h0, markers});
    chk("fast period", 1, period >= 16'd24 && period <= 16'd25);
    wr(10'h000, 32'h0);
    ticks(2);
    chk("serial oe off", 1, ser_oe_b);
    // Slow rate: marker in the first slot only
    wr(10'h000, 32'h1);
    wait_edge();
    chk("slow marker", 32'h3, {16'h0, markers});
    chk("slow slot 0", {31'h0, PAT[0]}, {31'h0, los_ser});
    wait_edge();
    chk("slow slot 1 mark", 0, marker);
    chk("slow period", 1, period >= 16'd6249 && period <= 16'd6251);
    wr(10'h000, 32'h0);
    chk("glitches", 0, glitches);
    chk("frame errors", 0, frame_err);
    for (int k = 0; k < 17; k++)
      ch_in[k].los <= 1'b0;
    ticks(4);
    drain(cnt, lastv);
    // Clock pin and data timing on channel 0
    {ch_in[0].rail_pos, ch_in[0].patt_match} <= 2'b11;
    pulse(0);
    chk("data on rise", 1, ch_out[0].data_or_pos);
    chk("mf pin", 1, ch_out[0].neg_or_mf);
    ch_in[0].rec_clk <= 1'b1;
    ticks(4);
    chk("clock pin", 1, ch_out[0].rec_clk_or_mf);
    ch_in[0].rail_pos <= 1'b0;
    ticks(4);
    chk("data held", 1, ch_out[0].data_or_pos);
    ch_in[0].rec_clk <= 1'b0;
    ticks(4);
    pulse(0);
    chk("data next rise", 0, ch_out[0].data_or_pos);
    wr(10'h200, 32'h08);
    pulse(0);
    chk("inverted data", 1, ch_out[0].data_or_pos);
    wr(10'h200, 32'h10);
    ch_in[0].rec_clk <= 1'b1;
    ticks(4);
    chk("no update on rise", 1, ch_out[0].data_or_pos);
    ch_in[0].rec_clk <= 1'b0;
    ticks(4);
    chk("update on fall", 0, ch_out[0].data_or_pos);
    wr(10'h100, 32'h1);
    {ch_in[0].rail_neg, ch_in[0].patt_match} <= 2'b10;
    pulse(0);
    chk("neg rail dual", 1, ch_out[0].neg_or_mf);
    // Sliced mode: clock pin carries each multiplex source
    wr(10'h110, 32'h3);
    {ch_in[4].patt_match, ch_in[4].bpv, ch_in[4].rail_pos} <= 3'b111;
    for (int c = 0; c < 8; c++)
    begin
      wr(10'h210, {24'h0, 3'(c), 5'h0});
      pulse(4);
      chk("mux output", {31'h0, MF_EXP[c]}, {31'h0, ch_out[4].rec_clk_or_mf});
    end
    // Line LOS on channel 1
    ch_in[1].los <= 1'b1;
    wr(10'h104, 32'h80);
    ticks(4);
    chk("los clock high", 1, ch_out[1].rec_clk_or_mf);
    wr(10'h104, 32'h0);
    ext_clk <= 1'b1;
    ticks(6);
    chk("los ext high", 1, ch_out[1].rec_clk_or_mf);
    ext_clk <= 1'b0;
    ticks(6);
    chk("los ext low", 0, ch_out[1].rec_clk_or_mf);
    // Powerdown on channel 2
    {ch_in[2].powerdown, ch_in[2].rec_clk} <= 2'b11;
    wr(10'h108, 32'h40);
    ticks(3);
    chk("pd hiz", 1, ch_out[2].clk_oe_b);
    chk("pd data hiz", 1, ch_out[2].data_oe_b);
    wr(10'h108, 32'h0);
    ticks(3);
    chk("pd driven", 0, ch_out[2].clk_oe_b);
    chk("pd low", 0, ch_out[2].rec_clk_or_mf);
    // Change log overfilled with nobody reading, then drained
    drain(cnt, lastv);
    for (int i = 0; i < 34; i++)
    begin
      ch_in[3].los <= ~ch_in[3].los;
      ticks(3);
    end
    drain(cnt, lastv);
    chk("log depth", 1, cnt >= 32 && cnt <= 35);
    chk("log final", 32'h2, {15'h0, lastv});
    drain(cnt, lastv);
    chk("log empty", 0, cnt);
    stop_test();
  end
endmodule
